/* File: hdl/ods_params.svh */
`ifndef ODS_PARAMS_SVH
`define ODS_PARAMS_SVH
`define ODS_IDX_HP 8'h5A
`define ODS_IDX_LINE 8'h5E
`define ODS_ADDR_HP 12'h168
`define ODS_ADDR_LINE 12'h178
`define ODS_ADDR_SEQ_CTRL 12'h400
`define ODS_ADDR_SEQ_WAIT 12'h404
`define ODS_ADDR_SEQ_STAT 12'h408
`define ODS_BIT_L_SHORT 7
`define ODS_BIT_L_OUT 6
`define ODS_BIT_L_MID 5
`define ODS_BIT_L_IN 4
`define ODS_BIT_R_SHORT 3
`define ODS_BIT_R_OUT 2
`define ODS_BIT_R_MID 1
`define ODS_BIT_R_IN 0
`define ODS_RST_CTRL 8'h00
`define ODS_MIN_DELAY_US 20
`define ODS_CLK_MHZ 50
`define ODS_MIN_DELAY_CYC 16'((`ODS_MIN_DELAY_US * `ODS_CLK_MHZ))
`endif

/* File: hdl/ods_pkg.sv */
package ods_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_INPUT,
        SEQ_WAIT,
        SEQ_MID,
        SEQ_DCWAIT,
        SEQ_OUT,
        SEQ_SHORT,
        SEQ_OFF
    } ods_state_t;
    typedef logic [7:0] ods_ctrl_t;
endpackage : ods_pkg

/* File: hdl/ods_sequencer.sv */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ods_params.svh"
module ods_sequencer (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dcCorrectionDone,
    output logic dcCorrectionStart,
    output ods_pkg::ods_ctrl_t hpCtrl,
    output ods_pkg::ods_ctrl_t lineCtrl
);
    import ods_pkg::*;

    ods_state_t state;
    ods_state_t next_state;
    ods_ctrl_t hpReg;
    ods_ctrl_t lineReg;
    logic [15:0] waitCount;
    logic [15:0] waitLoad;
    logic seqLine;
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic offPending;

    // Stage masks for one output pair, both channels at once.
    localparam ods_ctrl_t IN_MASK = 8'h11;
    localparam ods_ctrl_t MID_MASK = 8'h22;
    localparam ods_ctrl_t OUT_MASK = 8'h44;
    localparam ods_ctrl_t SHORT_MASK = 8'h88;

    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a == `ODS_ADDR_HP) || (a == `ODS_ADDR_LINE) ||
            (a == `ODS_ADDR_SEQ_CTRL) || (a == `ODS_ADDR_SEQ_WAIT) ||
            (a == `ODS_ADDR_SEQ_STAT);
    endfunction : isMapped

    function automatic ods_ctrl_t stepBits(input ods_ctrl_t cur, input ods_state_t st);
        unique case (st)
            SEQ_INPUT: stepBits = cur | IN_MASK;
            SEQ_MID: stepBits = cur | MID_MASK;
            SEQ_OUT: stepBits = cur | OUT_MASK;
            SEQ_SHORT: stepBits = cur | SHORT_MASK;
            SEQ_OFF: stepBits = cur & ~SHORT_MASK;
            SEQ_IDLE: stepBits = cur;
            SEQ_WAIT: stepBits = cur;
            SEQ_DCWAIT: stepBits = cur;
        endcase
    endfunction : stepBits

    wire writeFire = awHeld && wHeld && !s_axi_bvalid;
    wire busy = (state != SEQ_IDLE);
    wire lowLane = wStrb[0];
    wire wrHp = writeFire && lowLane && (awAddr == `ODS_ADDR_HP);
    wire wrLine = writeFire && lowLane && (awAddr == `ODS_ADDR_LINE);
    wire wrWait = writeFire && (awAddr == `ODS_ADDR_SEQ_WAIT);
    wire wrCtrl = writeFire && lowLane && (awAddr == `ODS_ADDR_SEQ_CTRL);
    wire startUp = wrCtrl && !busy && wData[0];
    wire shutDown = wrCtrl && !busy && wData[1];
    wire waitDone = (waitCount == 16'h0000);
    wire [15:0] newWait = {wStrb[1] ? wData[15:8] : waitLoad[15:8],
        wStrb[0] ? wData[7:0] : waitLoad[7:0]};
    ods_ctrl_t targetReg;
    assign targetReg = seqLine ? lineReg : hpReg;
    ods_ctrl_t stepped;
    assign stepped = stepBits(targetReg, state);

    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;
    assign dcCorrectionStart = (state == SEQ_DCWAIT);
    assign hpCtrl = hpReg;
    assign lineCtrl = lineReg;

    // Enable walks input, wait, mid, DC, out, short; disable clears short then all.
    always_comb begin
        next_state = state;
        unique case (state)
            SEQ_IDLE: begin
                if (startUp) next_state = SEQ_INPUT;
                else if (shutDown) next_state = SEQ_OFF;
            end
            SEQ_INPUT: next_state = SEQ_WAIT;
            SEQ_WAIT: if (waitDone) next_state = SEQ_MID;
            SEQ_MID: next_state = SEQ_DCWAIT;
            SEQ_DCWAIT: if (dcCorrectionDone) next_state = SEQ_OUT;
            SEQ_OUT: next_state = SEQ_SHORT;
            SEQ_SHORT: next_state = SEQ_IDLE;
            SEQ_OFF: next_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= SEQ_IDLE;
            seqLine <= 1'b0;
            waitCount <= 16'h0000;
        end else begin
            state <= next_state;
            if (!busy && wrCtrl) seqLine <= wData[2];
            if (state == SEQ_INPUT) waitCount <= waitLoad - 16'h0001;
            else if (!waitDone) waitCount <= waitCount - 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitLoad <= `ODS_MIN_DELAY_CYC;
        end else if (wrWait) begin
            // Zero would wrap the count to 16'hFFFF, the longest wait, so it is held at one cycle.
            waitLoad <= (newWait == 16'h0000) ? 16'h0001 : newWait;
        end
    end

    // Software writes are ignored while the sequencer owns the bits.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hpReg <= `ODS_RST_CTRL;
            lineReg <= `ODS_RST_CTRL;
        end else if (busy) begin
            if (state == SEQ_OFF) begin
                if (seqLine) lineReg <= lineReg & ~SHORT_MASK;
                else hpReg <= hpReg & ~SHORT_MASK;
            end else if (seqLine) lineReg <= stepped;
            else hpReg <= stepped;
        end else if (wrHp) begin
            hpReg <= wData[7:0];
        end else if (wrLine) begin
            lineReg <= wData[7:0];
        end else if (state == SEQ_IDLE && next_state == SEQ_IDLE && offPending) begin
            if (seqLine) lineReg <= 8'h00;
            else hpReg <= 8'h00;
        end
    end

    // Second disable step lands the cycle after the short is applied.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) offPending <= 1'b0;
        else offPending <= (state == SEQ_OFF);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 12'h000;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (writeFire) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(awAddr) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire [31:0] readWord =
        (s_axi_araddr == `ODS_ADDR_HP) ? {24'h000000, hpReg} :
        (s_axi_araddr == `ODS_ADDR_LINE) ? {24'h000000, lineReg} :
        (s_axi_araddr == `ODS_ADDR_SEQ_CTRL) ? {29'h00000000, seqLine, 2'h0} :
        (s_axi_araddr == `ODS_ADDR_SEQ_WAIT) ? {16'h0000, waitLoad} :
        (s_axi_araddr == `ODS_ADDR_SEQ_STAT) ? {28'h0000000, busy, 3'(state)} :
        32'h00000000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= isMapped(s_axi_araddr) ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_short_reset: assert property (
        @(posedge clock)
        $rose(nrst) |-> hpCtrl == 8'h00 && lineCtrl == 8'h00)
        else $error("short not applied after reset");

    a_mid_after_wait: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_INPUT) |=> (state == SEQ_WAIT) [*1] ##1
        (state != SEQ_MID || $past(waitDone)))
        else $error("mid stage before wait");

    a_wait_length: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_INPUT && waitLoad == `ODS_MIN_DELAY_CYC) |=> (state == SEQ_WAIT) [*8])
        else $error("wait cut short");

    a_wait_reload: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_INPUT) |=> waitCount == $past(waitLoad) - 16'h0001)
        else $error("wait counter not loaded");

    a_out_needs_dc: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_DCWAIT && !dcCorrectionDone) |=> state == SEQ_DCWAIT)
        else $error("output stage before DC done");

    a_dc_in_order: assert property (
        @(posedge clock) disable iff (!nrst)
        $rose(dcCorrectionStart) |-> $past(state) == SEQ_MID)
        else $error("DC correction out of order");

    a_out_after_dc: assert property (
        @(posedge clock) disable iff (!nrst)
        $rose(state == SEQ_OUT) |-> $past(dcCorrectionDone))
        else $error("output stage without DC done");

    a_start_order: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_OUT) |=> (state == SEQ_SHORT) ##1 (state == SEQ_IDLE))
        else $error("enable order broken");

    a_short_last: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_SHORT && !seqLine) |=> hpCtrl == 8'hFF)
        else $error("short released before stages");

    a_short_first: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_OFF) |=> ((seqLine ? lineCtrl : hpCtrl) & SHORT_MASK) == 8'h00)
        else $error("short not reapplied");

    a_all_off: assert property (
        @(posedge clock) disable iff (!nrst)
        (state == SEQ_OFF) ##1 !wrHp && !wrLine |=> (seqLine ? lineCtrl : hpCtrl) == 8'h00)
        else $error("stages not cleared");

    a_busy_locks_hp: assert property (
        @(posedge clock) disable iff (!nrst)
        (busy && seqLine) |=> $stable(hpCtrl))
        else $error("hp bits moved during line run");

    a_hp_write: assert property (
        @(posedge clock) disable iff (!nrst)
        (wrHp && !busy) |=> hpCtrl == $past(wData[7:0]))
        else $error("hp register not stored");

    a_line_write: assert property (
        @(posedge clock) disable iff (!nrst)
        (wrLine && !busy && !wrHp) |=> lineCtrl == $past(wData[7:0]))
        else $error("line register not stored");

    a_bvalid_holds: assert property (
        @(posedge clock) disable iff (!nrst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    a_rvalid_holds: assert property (
        @(posedge clock) disable iff (!nrst)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");

    a_unmapped_err: assert property (
        @(posedge clock) disable iff (!nrst)
        (s_axi_arvalid && !s_axi_rvalid && !isMapped(s_axi_araddr)) |=> s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
endmodule : ods_sequencer

/* File: verif/ods_dc_servo_model.sv */
`timescale 1ns/1ns
// DC servo stand-in: answers a correction request after a random 2 to 17 cycles.
module ods_dc_servo_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    output logic done
);
    int cnt;
    // Done drops as soon as the request goes away, so a stale level never leaks into a new run.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            done <= 1'b0;
        end else if (!start) begin
            cnt <= 1 + $urandom % 16;
            done <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            done <= 1'b1;
        end
    end
endmodule : ods_dc_servo_model

/* File: verif/output_driver_pop_sequencer_tb.sv */
`timescale 1ns/1ns
`include "ods_params.svh"
module output_driver_pop_sequencer_tb;
    logic clock = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rd, d;
    logic [1:0] br, rr, r;
    logic awr, wr, bv, arr, rv, dcStart, dcDone;
    logic [7:0] hpCtrl, lineCtrl;
    logic [3:0] ws = 4'hF;
    int n_errors = 0, total_checks = 0, cyc = 0, sel = 0, armDown = 0, i;
    int tIn, tMid, tDc, tOut, tSh, tShOff, tAll;
    int model[2] = '{0, 0};
    always #10 clock = ~clock;
    ods_sequencer DUT (.clock(clock), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rRdy), .dcCorrectionDone(dcDone),
        .dcCorrectionStart(dcStart), .hpCtrl(hpCtrl), .lineCtrl(lineCtrl));
    ods_dc_servo_model SERVO (.clock(clock), .nrst(nrst), .start(dcStart), .done(dcDone));
    function automatic logic [7:0] cur();
        return sel ? lineCtrl : hpCtrl;
    endfunction : cur
    // Records the cycle at which each step of a power-up or power-down first shows.
    always @(posedge clock) begin
        cyc++;
        if (tIn < 0 && cur()[4] && cur()[0]) tIn = cyc;
        if (tMid < 0 && cur()[5] && cur()[1]) tMid = cyc;
        if (tDc < 0 && dcStart) tDc = cyc;
        if (tOut < 0 && (cur()[6] || cur()[2])) tOut = cyc;
        if (tSh < 0 && (cur()[7] || cur()[3])) tSh = cyc;
        if (armDown && tShOff < 0 && !cur()[7] && !cur()[3]) tShOff = cyc;
        if (armDown && tAll < 0 && cur() === 8'h00) tAll = cyc;
    end
    task results();
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : check
    task hang(input string nm);
        $display("FAIL %s expected answer seen timeout", nm);
        n_errors++;
        results();
    endtask : hang
    task axiWrite(input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge clock);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bRdy <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clock);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        if (k >= 100) hang("writeResponse");
        r = br;
        bRdy <= 1'b0;
    endtask : axiWrite
    task axiRead(input logic [11:0] a);
        int k;
        @(posedge clock);
        ara <= a; arv <= 1'b1; rRdy <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clock);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        if (k >= 100) hang("readResponse");
        d = rd; r = rr;
        rRdy <= 1'b0;
    endtask : axiRead
    task waitFor(input logic [7:0] v);
        int k;
        for (k = 0; k < 3000 && cur() !== v; k++) @(posedge clock);
        if (k >= 3000) hang("sequenceEnd");
        // One more edge so the step recorder has logged the final value too.
        @(posedge clock);
    endtask : waitFor
    task runSeq(input int s, input int w);
        sel = s; armDown = 0;
        tIn = -1; tMid = -1; tDc = -1; tOut = -1; tSh = -1; tShOff = -1; tAll = -1;
        axiWrite(12'h400, s ? 32'h5 : 32'h1);
        waitFor(8'hFF);
        check("inputFirst", 1, tIn >= 0 && tIn < tMid);
        check("midDelay", 1, tMid - tIn >= w);
        check("dcAfterMid", 1, tDc >= tMid && tDc < tOut);
        check("outBeforeShort", 1, tOut < tSh);
        model[s] = 8'hFF;
        axiRead(s ? 12'h178 : 12'h168);
        check("regAfterUp", model[s], d);
        check("otherPath", 8'h00, s ? hpCtrl : lineCtrl);
        armDown = 1;
        axiWrite(12'h400, s ? 32'h6 : 32'h2);
        waitFor(8'h00);
        check("shortFirst", 1, tShOff >= 0 && tShOff < tAll);
        model[s] = 0;
    endtask : runSeq
    initial begin
        void'($urandom(5));
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        check("hpReset", 8'h00, hpCtrl);
        check("lineReset", 8'h00, lineCtrl);
        axiRead(12'h168);
        check("hpRegReset", 32'h0, d);
        axiRead(12'h178);
        check("lineRegReset", 32'h0, d);
        axiRead(12'h3FC);
        check("unmappedResp", 2'h2, r);
        for (i = 0; i < 6; i++) begin
            d = $urandom;
            axiWrite(i[0] ? 12'h178 : 12'h168, d);
            model[i[0]] = d[7:0];
            axiRead(i[0] ? 12'h178 : 12'h168);
            check("regReadback", model[i[0]], d);
            check("hpPins", model[0], hpCtrl);
            check("linePins", model[1], lineCtrl);
        end
        ws <= 4'h0;
        axiWrite(12'h168, 32'hAA);
        check("strobeIgnored", model[0], hpCtrl);
        ws <= 4'hF;
        axiWrite(12'h168, 32'h0);
        axiWrite(12'h178, 32'h0);
        model = '{0, 0};
        runSeq(0, `ODS_MIN_DELAY_US * `ODS_CLK_MHZ);
        axiWrite(12'h404, 32'h4);
        runSeq(1, 4);
        results();
    end
endmodule : output_driver_pop_sequencer_tb
